// *** rtl/apc_pkg.sv ***
// constants and types shared by the audio port configuration block
`default_nettype none
package apc_pkg;
   // register word indices; byte address is four times the index
   localparam logic [5:0] IDX_CTRL_ONE = 6'h03;
   localparam logic [5:0] IDX_CLK_CTRL = 6'h04;
   localparam logic [5:0] IDX_STATUS = 6'h05;
   localparam logic [7:0] CTRL_ONE_RST = 8'h00;
   localparam logic [7:0] CLK_CTRL_RST = 8'h00;
   localparam logic [7:0] CTRL_ONE_WMASK = 8'h7f;
   localparam logic [7:0] CLK_CTRL_WMASK = 8'h0f;
   // field positions in the first control register
   localparam int FMT_LSB = 0;
   localparam int ROLE_BIT = 3;
   localparam int SRC_LSB = 4;
   localparam int SILENCE_BIT = 6;

   typedef enum logic [2:0] {
      FMT_LJ24 = 3'b000,
      FMT_I2S24 = 3'b001,
      FMT_UNUSED2 = 3'b010,
      FMT_UNUSED3 = 3'b011,
      FMT_RJ16 = 3'b100,
      FMT_RJ18 = 3'b101,
      FMT_RJ20 = 3'b110,
      FMT_RJ24 = 3'b111
   } apc_fmt_e;

   typedef enum logic [1:0] {
      SRC_LOOP = 2'b00,
      SRC_OTHER = 2'b01,
      SRC_RX = 2'b10,
      SRC_CONV = 2'b11
   } apc_src_e;

   localparam int WORD_W = 24;
   localparam int SLOT_W = 5;
   localparam logic [4:0] SLOT_LAST = 5'h1f;
   localparam logic [5:0] SLOTS_HALF = 6'h20;
   localparam logic [5:0] LEN_LJ = 6'h18;
   localparam logic [5:0] LEN_RJ16 = 6'h10;
   localparam logic [5:0] LEN_RJ18 = 6'h12;
   localparam logic [5:0] LEN_RJ20 = 6'h14;
   localparam logic [5:0] LEN_RJ24 = 6'h18;
   // master clock generation from the system clock
   localparam int CLK_HZ = 25000000;
   localparam int BCK_HZ = 3125000;
   localparam int BCK_HALF_CYCLES = CLK_HZ / (2 * BCK_HZ);
   localparam logic [3:0] BCK_HALF_LAST = 4'(BCK_HALF_CYCLES - 1);
endpackage
`default_nettype wire

// *** rtl/apc_framer.sv ***
// slot to word bit mapping for one half frame of the serial port
`default_nettype none
module apc_framer (
   input wire logic [2:0] fmt_i,
   input wire logic [4:0] slot_i,
   output logic valid_o,
   output logic [4:0] pos_o
);
   logic [5:0] len;
   logic [5:0] s;
   always_comb begin
      len = apc_pkg::LEN_LJ;
      s = {1'b0, slot_i};
      valid_o = 1'b0;
      pos_o = 5'h00;
      case (fmt_i)
         apc_pkg::FMT_I2S24: begin
            // data starts one bit clock after the word clock edge
            if (s >= 6'h01 && s <= apc_pkg::LEN_LJ) begin
               valid_o = 1'b1;
               pos_o = 5'(apc_pkg::LEN_LJ - s);
            end
         end
         apc_pkg::FMT_RJ16, apc_pkg::FMT_RJ18, apc_pkg::FMT_RJ20, apc_pkg::FMT_RJ24: begin
            case (fmt_i[1:0])
               2'b00: len = apc_pkg::LEN_RJ16;
               2'b01: len = apc_pkg::LEN_RJ18;
               2'b10: len = apc_pkg::LEN_RJ20;
               default: len = apc_pkg::LEN_RJ24;
            endcase
            // word ends on the last slot; msb-aligned word bits are sent
            if (s >= apc_pkg::SLOTS_HALF - len) begin
               valid_o = 1'b1;
               pos_o = 5'(apc_pkg::SLOTS_HALF + apc_pkg::LEN_LJ - 6'h01 - len - s);
            end
         end
         default: begin
            if (s < apc_pkg::LEN_LJ) begin
               valid_o = 1'b1;
               pos_o = 5'(apc_pkg::LEN_LJ - 6'h01 - s);
            end
         end
      endcase
   end
endmodule
`default_nettype wire

// *** rtl/apc_port.sv ***
// first audio serial port: register file, clocking, routing and muting
//
// Behaviour
// - format field picks left-justified, I2S or right-justified 16/18/20/24 framing
// - clock role 0: port is slave, word and bit clocks are inputs
// - clock role 1: port drives word and bit clocks from master source
// - source field routes loopback, other port, receiver or converter to output
// - silence bit 1 holds the serial output low
`default_nettype none
module apc_port (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic word_clock_i,
   output logic word_clock_o,
   output logic word_clock_oe_o,
   input wire logic bit_clock_i,
   output logic bit_clock_o,
   output logic bit_clock_oe_o,
   input wire logic port_serial_in_i,
   output logic port_serial_out_o,
   input wire logic [23:0] other_port_left_i,
   input wire logic [23:0] other_port_right_i,
   input wire logic [23:0] rx_left_i,
   input wire logic [23:0] rx_right_i,
   input wire logic [23:0] conv_left_i,
   input wire logic [23:0] conv_right_i
);
   logic [7:0] ctrl_one_q;
   logic [7:0] clk_ctrl_q;
   logic [2:0] port_format_sel;
   logic port_clock_role;
   logic [1:0] port_output_source;
   logic port_output_silence;
   logic bus_req;
   logic [5:0] bus_idx;
   logic [31:0] rd_d;

   assign port_format_sel = ctrl_one_q[apc_pkg::FMT_LSB +: 3];
   assign port_clock_role = ctrl_one_q[apc_pkg::ROLE_BIT];
   assign port_output_source = ctrl_one_q[apc_pkg::SRC_LSB +: 2];
   assign port_output_silence = ctrl_one_q[apc_pkg::SILENCE_BIT];
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_idx = wb_adr_i[7:2];

   // single-cycle answer: ack one edge after the request, dropped the next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= (bus_req && !wb_we_i) ? rd_d : 32'h0000_0000;
      end
   end

   // only byte lane 0 holds data; the other lanes are ignored on write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_one_q <= apc_pkg::CTRL_ONE_RST;
         clk_ctrl_q <= apc_pkg::CLK_CTRL_RST;
      end else if (bus_req && wb_we_i && wb_sel_i[0]) begin
         if (bus_idx == apc_pkg::IDX_CTRL_ONE) begin
            ctrl_one_q <= wb_dat_i[7:0] & apc_pkg::CTRL_ONE_WMASK;
         end
         if (bus_idx == apc_pkg::IDX_CLK_CTRL) begin
            clk_ctrl_q <= wb_dat_i[7:0] & apc_pkg::CLK_CTRL_WMASK;
         end
      end
   end

   // ---------------- clock pins ----------------
   logic bck_s1_q;
   logic bck_s2_q;
   logic wck_s1_q;
   logic wck_s2_q;
   logic sd_s1_q;
   logic sd_s2_q;
   logic [3:0] div_q;
   logic [4:0] bcnt_q;

   // pins from the far party are synchronised before any use
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bck_s1_q <= 1'b0;
         bck_s2_q <= 1'b0;
         wck_s1_q <= 1'b0;
         wck_s2_q <= 1'b0;
         sd_s1_q <= 1'b0;
         sd_s2_q <= 1'b0;
      end else begin
         bck_s1_q <= bit_clock_i;
         bck_s2_q <= bck_s1_q;
         wck_s1_q <= word_clock_i;
         wck_s2_q <= wck_s1_q;
         sd_s1_q <= port_serial_in_i;
         sd_s2_q <= sd_s1_q;
      end
   end

   // master clocks run all the time; the role only gates the enables,
   // so switching role never truncates a bit clock phase
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q <= 4'h0;
         bcnt_q <= 5'h00;
         bit_clock_o <= 1'b0;
         word_clock_o <= 1'b0;
      end else if (div_q == apc_pkg::BCK_HALF_LAST) begin
         div_q <= 4'h0;
         bit_clock_o <= ~bit_clock_o;
         if (bit_clock_o) begin
            bcnt_q <= bcnt_q + 5'h01;
            if (bcnt_q == apc_pkg::SLOT_LAST) begin
               word_clock_o <= ~word_clock_o;
            end
         end
      end else begin
         div_q <= div_q + 4'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bit_clock_oe_o <= 1'b0;
         word_clock_oe_o <= 1'b0;
      end else begin
         // slave keeps both pins released for the far party to drive
         bit_clock_oe_o <= port_clock_role;
         word_clock_oe_o <= port_clock_role;
      end
   end

   // ---------------- framing ----------------
   logic bck_lvl;
   logic wck_lvl;
   logic bck_prev_q;
   logic wck_last_q;
   logic rise_p;
   logic fall_p;
   logic load_p;
   logic left_now;
   logic [4:0] slot_q;
   logic [4:0] slot_nx;
   logic in_valid;
   logic [4:0] in_pos;
   logic out_valid;
   logic [4:0] out_pos;

   assign bck_lvl = port_clock_role ? bit_clock_o : bck_s2_q;
   assign wck_lvl = port_clock_role ? word_clock_o : wck_s2_q;
   assign rise_p = bck_lvl & ~bck_prev_q;
   assign fall_p = ~bck_lvl & bck_prev_q;
   assign load_p = fall_p & (wck_lvl != wck_last_q);
   // I2S puts the left word on the low word clock phase
   assign left_now = (port_format_sel == apc_pkg::FMT_I2S24) ? ~wck_lvl : wck_lvl;
   assign slot_nx = load_p ? 5'h00 :
                    (slot_q == apc_pkg::SLOT_LAST) ? slot_q : slot_q + 5'h01;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bck_prev_q <= 1'b0;
         wck_last_q <= 1'b0;
         slot_q <= apc_pkg::SLOT_LAST;
      end else begin
         bck_prev_q <= bck_lvl;
         if (fall_p) begin
            wck_last_q <= wck_lvl;
            slot_q <= slot_nx;
         end
      end
   end

   // input capture uses the current slot, output uses the one being entered
   apc_framer u_in_map (
      .fmt_i(port_format_sel),
      .slot_i(slot_q),
      .valid_o(in_valid),
      .pos_o(in_pos)
   );
   apc_framer u_out_map (
      .fmt_i(port_format_sel),
      .slot_i(slot_nx),
      .valid_o(out_valid),
      .pos_o(out_pos)
   );

   // ---------------- data path ----------------
   logic [23:0] cap_q;
   logic [23:0] loop_left_q;
   logic [23:0] loop_right_q;
   logic [23:0] out_word_q;
   logic [23:0] sel_word;
   logic [23:0] word_nx;
   logic ser_bit_q;

   // loopback words come one frame late; the other sources are taken as is
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap_q <= 24'h000000;
         loop_left_q <= 24'h000000;
         loop_right_q <= 24'h000000;
      end else if (load_p) begin
         cap_q <= 24'h000000;
         if (left_now) begin
            loop_right_q <= cap_q;
         end else begin
            loop_left_q <= cap_q;
         end
      end else if (rise_p && in_valid) begin
         cap_q[in_pos] <= sd_s2_q;
      end
   end

   always_comb begin
      case (port_output_source)
         apc_pkg::SRC_LOOP: sel_word = left_now ? loop_left_q : loop_right_q;
         apc_pkg::SRC_OTHER: sel_word = left_now ? other_port_left_i : other_port_right_i;
         apc_pkg::SRC_RX: sel_word = left_now ? rx_left_i : rx_right_i;
         default: sel_word = left_now ? conv_left_i : conv_right_i;
      endcase
   end
   assign word_nx = load_p ? sel_word : out_word_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_word_q <= 24'h000000;
         ser_bit_q <= 1'b0;
      end else if (fall_p) begin
         out_word_q <= word_nx;
         // unused slots are padded low
         ser_bit_q <= out_valid ? word_nx[out_pos] : 1'b0;
      end
   end

   // muting acts at once, not at the next word boundary
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_serial_out_o <= 1'b0;
      end else begin
         port_serial_out_o <= port_output_silence ? 1'b0 : ser_bit_q;
      end
   end

   always_comb begin
      rd_d = 32'h0000_0000;
      case (bus_idx)
         apc_pkg::IDX_CTRL_ONE: rd_d = {24'h000000, ctrl_one_q};
         apc_pkg::IDX_CLK_CTRL: rd_d = {24'h000000, clk_ctrl_q};
         apc_pkg::IDX_STATUS: rd_d = {29'h00000000, left_now, wck_lvl, bck_lvl};
         default: rd_d = 32'h0000_0000;
      endcase
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_silence_low;
      port_output_silence |=> !port_serial_out_o;
   endproperty
   a_silence_low: assert property (p_silence_low)
      else $error("serial output not low while muted");

   property p_slave_released;
      !port_clock_role |=> (!bit_clock_oe_o && !word_clock_oe_o);
   endproperty
   a_slave_released: assert property (p_slave_released)
      else $error("clock pins driven in slave role");

   property p_master_driven;
      (port_clock_role && $past(port_clock_role)) |-> (bit_clock_oe_o && word_clock_oe_o);
   endproperty
   a_master_driven: assert property (p_master_driven)
      else $error("clock pins not driven in master role");

   property p_master_half_period;
      $rose(bit_clock_o) |=> $stable(bit_clock_o) [*3] ##1 $fell(bit_clock_o);
   endproperty
   a_master_half_period: assert property (p_master_half_period)
      else $error("master bit clock half period wrong");

   property p_word_on_fall;
      $changed(word_clock_o) |-> $fell(bit_clock_o);
   endproperty
   a_word_on_fall: assert property (p_word_on_fall)
      else $error("word clock moved off a bit clock fall");

   property p_conv_routed;
      (load_p && port_output_source == apc_pkg::SRC_CONV)
         |=> out_word_q == ($past(left_now) ? $past(conv_left_i) : $past(conv_right_i));
   endproperty
   a_conv_routed: assert property (p_conv_routed)
      else $error("converter word not routed");

   property p_rx_routed;
      (load_p && port_output_source == apc_pkg::SRC_RX && left_now)
         |=> out_word_q == $past(rx_left_i);
   endproperty
   a_rx_routed: assert property (p_rx_routed)
      else $error("receiver word not routed");

   property p_rj16_pad;
      (fall_p && port_format_sel == apc_pkg::FMT_RJ16 && slot_nx < 5'h10)
         |=> !ser_bit_q;
   endproperty
   a_rj16_pad: assert property (p_rj16_pad)
      else $error("right-justified pad slot not low");

   property p_lj_first_bit;
      (fall_p && load_p && port_format_sel == apc_pkg::FMT_LJ24)
         |=> ser_bit_q == out_word_q[23];
   endproperty
   a_lj_first_bit: assert property (p_lj_first_bit)
      else $error("left-justified msb not on first slot");

   c_master_frame: cover property (port_clock_role && load_p);
   c_slave_frame: cover property (!port_clock_role && load_p);
   c_i2s_loop: cover property (port_format_sel == apc_pkg::FMT_I2S24 && load_p
                               && port_output_source == apc_pkg::SRC_LOOP);
   c_muted_frame: cover property (port_output_silence && load_p);
endmodule
`default_nettype wire

// *** bench/apc_audio_partner.sv ***
// behavioural external audio source: word and bit clocks plus serial data
`default_nettype none
module apc_audio_partner #(
   parameter logic [23:0] WORD = 24'h0000ff
) (
   input wire logic bit_clock_i,
   input wire logic word_clock_i,
   output logic bit_clock_o,
   output logic word_clock_o,
   output logic serial_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic wc_last = 1'b0;
   int slot = 0;
   int falls = 0;
   // audio clocks run free; a 300 ns phase stays well above the 3-cycle minimum,
   // and the 10 ns offset keeps pin edges off the system clock edges
   initial begin
      bit_clock_o = 1'b0;
      word_clock_o = 1'b0;
      serial_o = 1'b0;
      #10;
      forever #300 bit_clock_o = ~bit_clock_o;
   end
   always @(negedge bit_clock_o) begin
      falls = (falls == 31) ? 0 : falls + 1;
      if (falls == 0) word_clock_o = ~word_clock_o;
   end
   // data follows the clocks on the line; slots past the word toggle, never hold
   always @(negedge bit_clock_i) begin
      #1;
      slot = (word_clock_i != wc_last) ? 0 : slot + 1;
      wc_last = word_clock_i;
      serial_o = (slot < 24) ? WORD[23 - slot] : ~serial_o;
   end
endmodule
`default_nettype wire

// *** bench/apc_port_tb.sv ***
// self-checking bench for the first audio port configuration block
`default_nettype none
module apc_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_dat = 32'h0;
   logic [31:0] wb_rdat;
   logic [31:0] rdat;
   logic ack, wc_o, wc_oe, bc_o, bc_oe, sout, p_bck, p_word_clock, p_ser;
   logic p_en = 1'b0;
   logic [23:0] other_w = 24'h555555;
   logic [23:0] rx_w = 24'hffffff;
   logic [23:0] conv_w = 24'h000001;
   int num_errors = 0;
   int compares = 0;
   // undriven clock lines fall to a pull-down
   wire logic bck_line = bc_oe ? bc_o : (p_en ? p_bck : 1'b0);
   wire logic word_clock_line = wc_oe ? wc_o : (p_en ? p_word_clock : 1'b0);

   always #20 clk_i = ~clk_i;

   apc_port u_apc_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_rdat), .wb_ack_o(ack), .word_clock_i(word_clock_line), .word_clock_o(wc_o),
      .word_clock_oe_o(wc_oe), .bit_clock_i(bck_line), .bit_clock_o(bc_o),
      .bit_clock_oe_o(bc_oe), .port_serial_in_i(p_ser), .port_serial_out_o(sout),
      .other_port_left_i(other_w), .other_port_right_i(other_w), .rx_left_i(rx_w),
      .rx_right_i(rx_w), .conv_left_i(conv_w), .conv_right_i(conv_w));

   apc_audio_partner u_apc_audio_partner (.bit_clock_i(bck_line), .word_clock_i(word_clock_line),
      .bit_clock_o(p_bck), .word_clock_o(p_word_clock), .serial_o(p_ser));

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // one classic cycle; entered just after a rising edge
   task automatic wb_xfer(input logic we, input logic [5:0] idx, input logic [7:0] wd,
                          input logic [3:0] sel = 4'hf);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= {idx, 2'b00};
      wb_sel <= sel;
      wb_dat <= {24'h0, wd};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 16);
      if (ack !== 1'b1) begin
         num_errors++;
         wrap_up();
      end
      rdat = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      @(posedge clk_i);
   endtask

   // ones on the serial output over 64 bit-clock rises, i.e. one full frame
   task automatic count_ones(output int ones);
      int n, k;
      logic prev;
      ones = 0;
      k = 0;
      n = 0;
      prev = bck_line;
      while (k < 64 && n < 5000) begin
         @(posedge clk_i);
         n++;
         if (bck_line === 1'b1 && prev === 1'b0) begin
            k++;
            if (sout === 1'b1) ones++;
         end
         prev = bck_line;
      end
      if (k < 64) begin
         num_errors++;
         wrap_up();
      end
   endtask

   // loopback needs a frame pair to settle, so two frames are thrown away
   task automatic cfg_count(input logic [7:0] ctrl, input int exp);
      int ones;
      wb_xfer(1'b1, apc_pkg::IDX_CTRL_ONE, ctrl);
      count_ones(ones);
      count_ones(ones);
      count_ones(ones);
      check($sformatf("ones ctrl %h", ctrl), 32'(exp), 32'(ones));
   endtask

   task automatic half_len(input logic pick_word, output int n);
      logic v0;
      for (int i = 0; i < 2; i++) begin
         n = 0;
         v0 = pick_word ? wc_o : bc_o;
         while ((pick_word ? wc_o : bc_o) === v0 && n < 600) begin
            @(posedge clk_i);
            n++;
         end
      end
   endtask

   task automatic t_regs();
      check("oe after reset", 32'h0, {30'h0, wc_oe, bc_oe});
      wb_xfer(1'b0, apc_pkg::IDX_CTRL_ONE, 8'h00);
      check("ctrl one reset", {24'h0, apc_pkg::CTRL_ONE_RST}, rdat);
      wb_xfer(1'b0, apc_pkg::IDX_CLK_CTRL, 8'h00);
      check("clock ctrl reset", {24'h0, apc_pkg::CLK_CTRL_RST}, rdat);
      wb_xfer(1'b1, apc_pkg::IDX_CTRL_ONE, 8'hff);
      wb_xfer(1'b0, apc_pkg::IDX_CTRL_ONE, 8'h00);
      check("ctrl one rw", 32'h7f, rdat);
      wb_xfer(1'b1, apc_pkg::IDX_CLK_CTRL, 8'hff);
      wb_xfer(1'b0, apc_pkg::IDX_CLK_CTRL, 8'h00);
      check("clock ctrl rw", 32'h0f, rdat);
      // lane 0 not selected: the write must be ignored
      wb_xfer(1'b1, apc_pkg::IDX_CLK_CTRL, 8'h05, 4'he);
      wb_xfer(1'b0, apc_pkg::IDX_CLK_CTRL, 8'h00);
      check("clock ctrl lane0 off", 32'h0f, rdat);
      wb_xfer(1'b1, 6'h3f, 8'hff);
      wb_xfer(1'b0, 6'h3f, 8'h00);
      check("unmapped read", 32'h0, rdat);
      // released clock lines sit low, so the I2S left phase reads as active
      wb_xfer(1'b1, apc_pkg::IDX_CTRL_ONE, 8'h01);
      wb_xfer(1'b0, apc_pkg::IDX_STATUS, 8'h00);
      check("status idle i2s", 32'h4, rdat);
   endtask

   task automatic t_slave();
      p_en <= 1'b1;
      cfg_count(8'h10, 24);
      check("slave oe", 32'h0, {30'h0, wc_oe, bc_oe});
   endtask

   task automatic t_master();
      int n;
      wb_xfer(1'b1, apc_pkg::IDX_CTRL_ONE, 8'h18);
      repeat (2) @(posedge clk_i);
      check("master oe", 32'h3, {30'h0, wc_oe, bc_oe});
      half_len(1'b0, n);
      check("bit clock half", 32'(apc_pkg::BCK_HALF_CYCLES), 32'(n));
      half_len(1'b1, n);
      check("word clock half", 32'(64 * apc_pkg::BCK_HALF_CYCLES), 32'(n));
   endtask

   task automatic t_formats();
      int exp_ones [8] = '{24, 24, 24, 24, 16, 18, 20, 24};
      for (int c = 0; c < 8; c++) begin
         cfg_count(8'h18 | 8'(c), exp_ones[c]);
      end
   endtask

   task automatic t_sources();
      int exp_ones [4] = '{16, 24, 48, 2};
      for (int s = 0; s < 4; s++) begin
         cfg_count(8'h08 | 8'(s << 4), exp_ones[s]);
      end
      cfg_count(8'h3f, 2);
   endtask

   task automatic t_silence();
      int n;
      n = 0;
      wb_xfer(1'b1, apc_pkg::IDX_CTRL_ONE, 8'h18);
      while (sout !== 1'b1 && n < 2000) begin
         @(posedge clk_i);
         n++;
      end
      check("output before mute", 32'h1, {31'h0, sout});
      wb_xfer(1'b1, apc_pkg::IDX_CTRL_ONE, 8'h58);
      check("silenced output", 32'h0, {31'h0, sout});
      cfg_count(8'h58, 0);
      cfg_count(8'h18, 24);
   endtask

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_slave();
      t_master();
      t_formats();
      t_sources();
      t_silence();
      wrap_up();
   end
endmodule
`default_nettype wire
